// *** core/npb_cfg.svh ***
// register offsets, field positions, reset values and timing counts
// for the nibble port block; included by the design and by the bench.
`ifndef NPB_CFG_SVH
`define NPB_CFG_SVH

// ==========================================================
// register byte offsets (AHB-Lite, one word per register)
// ==========================================================
`define NPB_OFF_PDATA 8'h00
`define NPB_OFF_PDATA_END 8'h30
`define NPB_OFF_PAIR45 8'h30
`define NPB_OFF_PAIR67 8'h34
`define NPB_OFF_DIRG 8'h40
`define NPB_OFF_DIRB 8'h44
`define NPB_OFF_PULL 8'h48
`define NPB_OFF_ALT 8'h4c
`define NPB_OFF_EDGE 8'h50
`define NPB_OFF_STAT 8'h54
`define NPB_OFF_MASK 8'h58
`define NPB_OFF_TEST 8'h5c

// ==========================================================
// field positions
// ==========================================================
// group direction bits
`define NPB_DG_P2 0
`define NPB_DG_P4 1
`define NPB_DG_P5 2
`define NPB_DG_P7 3
`define NPB_DG_P8 4
`define NPB_DG_P9 5
`define NPB_DG_P10 6
// pull-up group bits: 0 = input_port_a upper three, then ports 1,2,3,6,7,8,9
`define NPB_PU_P0 0
`define NPB_PU_P1 1
`define NPB_PU_P2 2
`define NPB_PU_P3 3
`define NPB_PU_P6 4
`define NPB_PU_P7 5
`define NPB_PU_P8 6
`define NPB_PU_P9 7
// alternate function: bits 3:0 port2 pins, bit 4 port10 converter mode
`define NPB_ALT_P10 4
// event / status / mask bits
`define NPB_EV_IRQ_D 0
`define NPB_EV_IRQ_A 1
`define NPB_EV_IRQ_B 2
`define NPB_EV_TEST 3
`define NPB_EV_KEY 4

// ==========================================================
// reset values and timing
// ==========================================================
`define NPB_RST_READY 1'b1
`define NPB_CLK_PERIOD_NS 8
`define NPB_NF_TIME_NS 100
`define NPB_NF_CYC \
	((`NPB_NF_TIME_NS + `NPB_CLK_PERIOD_NS - 1) / `NPB_CLK_PERIOD_NS)

`endif

// *** core/npb_pkg.sv ***
// state types of the nibble port block.
// assumes nothing of its surroundings.
`default_nettype none

package npb_pkg;

	// ==========================================================
	// edge detector state
	// ==========================================================
	typedef struct packed {
		logic in_q;
		logic stable;
		logic [7:0] cnt;
		logic pulse;
	} npb_edge_st_t;

	// ==========================================================
	// top-level state
	// ==========================================================
	typedef struct packed {
		logic [11:0][3:0] lat;
		logic [6:0] dir_grp;
		logic [7:0] dir_bit;
		logic [7:0] pu;
		logic [4:0] alt;
		logic [2:0] edge_sel;
		logic [4:0] status;
		logic [4:0] mask;
		logic [11:0][3:0] pout;
		logic [11:0][3:0] poe_b;
		logic irq;
		logic cmp;
		logic evc;
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
		logic ph_wr;
		logic [7:0] ph_addr;
	} npb_st_t;

endpackage : npb_pkg

`default_nettype wire

// *** core/npb_edge_det.sv ***
// one edge detector with optional noise filter.
// assumes din is synchronous to clk; FILT_CYC = 0 gives no filter.
`timescale 1ns/1ps
`default_nettype none

module npb_edge_det
	import npb_pkg::*;
#(
	parameter int FILT_CYC = 0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// signal and edge choice (1 = rising)
	input wire logic din,
	input wire logic rise_sel,
	// one-cycle event
	output logic pulse
);

	npb_edge_st_t st_reg;
	npb_edge_st_t st_next;
	logic newval;

	// ==========================================================
	// filter and edge compare
	// ==========================================================
	always_comb begin
		st_next = st_reg;
		st_next.in_q = din;
		newval = st_reg.stable;
		if (FILT_CYC == 0) begin
			newval = din;
		end else if (st_reg.in_q == st_reg.stable) begin
			st_next.cnt = 8'h00;
		end else if (st_reg.cnt == 8'(FILT_CYC - 1)) begin
			// level held long enough to be accepted
			newval = st_reg.in_q;
			st_next.cnt = 8'h00;
		end else begin
			st_next.cnt = st_reg.cnt + 8'h01;
		end
		st_next.stable = newval;
		st_next.pulse = (newval != st_reg.stable) && (newval == rise_sel);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	assign pulse = st_reg.pulse;

endmodule // npb_edge_det

`default_nettype wire

// *** core/npb_top.sv ***
// nibble port block: twelve 4-bit ports, pull-up and direction control,
// alternate functions and edge detection, behind an AHB-Lite slave.
// assumes pins synchronous to sys_clk; the pad resolves out/oe_b.
//
// Our own choices: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "npb_cfg.svh"

module npb_top
	import npb_pkg::*;
(
	// clock, reset, enable
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic ce,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// input-only ports
	input wire logic [3:0] input_port_a,
	input wire logic [3:0] p1_in,
	input wire logic [3:0] analog_shared_input_port,
	input wire logic sub_osc_in,
	// CMOS and open-drain I/O ports
	input wire logic [3:0] p2_in,
	output logic [3:0] p2_out,
	output logic [3:0] p2_oe_b,
	input wire logic [3:0] p3_in,
	output logic [3:0] p3_out,
	output logic [3:0] p3_oe_b,
	input wire logic [3:0] p4_in,
	output logic [3:0] p4_out,
	output logic [3:0] p4_oe_b,
	input wire logic [3:0] p5_in,
	output logic [3:0] p5_out,
	output logic [3:0] p5_oe_b,
	input wire logic [3:0] p6_in,
	output logic [3:0] p6_out,
	output logic [3:0] p6_oe_b,
	input wire logic [3:0] p7_in,
	output logic [3:0] p7_out,
	output logic [3:0] p7_oe_b,
	input wire logic [3:0] p8_in,
	output logic [3:0] p8_out,
	output logic [3:0] p8_oe_b,
	input wire logic [3:0] p9_in,
	output logic [3:0] p9_out,
	output logic [3:0] p9_oe_b,
	input wire logic [3:0] p10_in,
	output logic [3:0] p10_out,
	output logic [3:0] p10_oe_b,
	// pull-up enables
	output logic [2:0] pu_p0,
	output logic [3:0] pu_p1,
	output logic [3:0] pu_p2,
	output logic [3:0] pu_p3,
	output logic [3:0] pu_p6,
	output logic [3:0] pu_p7,
	output logic [3:0] pu_p8,
	output logic [3:0] pu_p9,
	// peripheral sources for shared pins
	input wire logic timer_square_out,
	input wire logic mft_pulse_out,
	input wire logic prog_clock_out,
	input wire logic beeper_out,
	input wire logic reverse_integrate_ctl,
	input wire logic integrate_ctl,
	input wire logic autozero_ctl,
	// pin levels to peripherals and interrupt
	output logic comparator_in,
	output logic event_count_input,
	output logic irq
);

	npb_st_t st_reg;
	npb_st_t st_next;
	logic [1:0] rst_sync;
	logic rst_n;
	logic [11:0][3:0] pin;
	logic [11:0][3:0] dirv;
	logic [11:0][3:0] drv;
	logic [7:0] key_ev;
	logic [4:0] ev;
	logic [4:0] clr;
	logic aphase;

	// open-drain ports read pin levels in either direction
	function automatic logic is_od(input int n);
		return (n == 4) || (n == 5) || (n == 10);
	endfunction

	// output bits read back the latch, input bits the pin
	function automatic logic [3:0] port_rd(input logic [3:0] p,
		input logic [3:0] l, input logic [3:0] d, input logic od);
		return od ? p : ((d & l) | (~d & p));
	endfunction

	// ==========================================================
	// reset release
	// ==========================================================
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// ==========================================================
	// pin collection
	// ==========================================================
	assign pin[0] = input_port_a;
	assign pin[1] = p1_in;
	assign pin[2] = p2_in;
	assign pin[3] = p3_in;
	assign pin[4] = p4_in;
	assign pin[5] = p5_in;
	assign pin[6] = p6_in;
	assign pin[7] = p7_in;
	assign pin[8] = p8_in;
	assign pin[9] = p9_in;
	assign pin[10] = p10_in;
	assign pin[11] = analog_shared_input_port;

	// ==========================================================
	// edge detectors
	// ==========================================================
	npb_edge_det #(.FILT_CYC(0)) u_irq_d (
		.clk(sys_clk), .rst_n(rst_n), .ce(ce),
		.din(input_port_a[0]), .rise_sel(st_reg.edge_sel[0]),
		.pulse(ev[`NPB_EV_IRQ_D])
	);
	// filtered: a glitch shorter than the filter never raises an event
	npb_edge_det #(.FILT_CYC(`NPB_NF_CYC)) u_irq_a (
		.clk(sys_clk), .rst_n(rst_n), .ce(ce),
		.din(p1_in[0]), .rise_sel(st_reg.edge_sel[1]),
		.pulse(ev[`NPB_EV_IRQ_A])
	);
	npb_edge_det #(.FILT_CYC(0)) u_irq_b (
		.clk(sys_clk), .rst_n(rst_n), .ce(ce),
		.din(p1_in[1]), .rise_sel(st_reg.edge_sel[2]),
		.pulse(ev[`NPB_EV_IRQ_B])
	);
	npb_edge_det #(.FILT_CYC(0)) u_test (
		.clk(sys_clk), .rst_n(rst_n), .ce(ce),
		.din(p1_in[2]), .rise_sel(1'b1),
		.pulse(ev[`NPB_EV_TEST])
	);
	for (genvar k = 0; k < 8; k++) begin : g_key
		npb_edge_det #(.FILT_CYC(0)) u_key (
			.clk(sys_clk), .rst_n(rst_n), .ce(ce),
			.din(k < 4 ? p6_in[k % 4] : p7_in[k % 4]),
			.rise_sel(1'b0),
			.pulse(key_ev[k])
		);
	end
	assign ev[`NPB_EV_KEY] = |key_ev;

	assign aphase = hsel && hready && htrans[1];

	// ==========================================================
	// next state
	// ==========================================================
	always_comb begin
		st_next = st_reg;
		dirv = '0;
		dirv[3] = st_reg.dir_bit[3:0];
		dirv[6] = st_reg.dir_bit[7:4];
		dirv[2] = {4{st_reg.dir_grp[`NPB_DG_P2]}} | st_reg.alt[3:0];
		dirv[4] = {4{st_reg.dir_grp[`NPB_DG_P4]}};
		dirv[5] = {4{st_reg.dir_grp[`NPB_DG_P5]}};
		dirv[7] = {4{st_reg.dir_grp[`NPB_DG_P7]}};
		dirv[8] = {4{st_reg.dir_grp[`NPB_DG_P8]}};
		dirv[9] = {4{st_reg.dir_grp[`NPB_DG_P9]}};
		dirv[10] = {4{st_reg.dir_grp[`NPB_DG_P10]}};
		drv = st_reg.lat;
		drv[2] = (st_reg.alt[3:0] & {beeper_out, prog_clock_out,
			mft_pulse_out, timer_square_out})
			| (~st_reg.alt[3:0] & st_reg.lat[2]);
		if (st_reg.alt[`NPB_ALT_P10]) begin
			// converter mode: bit 3 stays an input for the comparator
			dirv[10] = 4'h7;
			drv[10] = {1'b1, autozero_ctl, integrate_ctl,
				reverse_integrate_ctl};
		end
		for (int n = 2; n < 11; n++) begin
			if (is_od(n)) begin
				// open drain only pulls low; a high latch releases
				st_next.pout[n] = 4'h0;
				st_next.poe_b[n] = ~(dirv[n] & ~drv[n]);
			end else begin
				st_next.pout[n] = drv[n];
				st_next.poe_b[n] = ~dirv[n];
			end
		end
		clr = 5'h00;
		st_next.hreadyout = 1'b1;
		st_next.hresp = 1'b0;
		if (st_reg.ph_wr) begin
			if (st_reg.ph_addr < `NPB_OFF_PDATA_END) begin
				st_next.lat[st_reg.ph_addr[5:2]] = hwdata[3:0];
			end
			case (st_reg.ph_addr)
				`NPB_OFF_PAIR45: begin
					st_next.lat[4] = hwdata[3:0];
					st_next.lat[5] = hwdata[7:4];
				end
				`NPB_OFF_PAIR67: begin
					st_next.lat[6] = hwdata[3:0];
					st_next.lat[7] = hwdata[7:4];
				end
				`NPB_OFF_DIRG: st_next.dir_grp = hwdata[6:0];
				`NPB_OFF_DIRB: st_next.dir_bit = hwdata[7:0];
				`NPB_OFF_PULL: st_next.pu = hwdata[7:0];
				`NPB_OFF_ALT: st_next.alt = hwdata[4:0];
				`NPB_OFF_EDGE: st_next.edge_sel = hwdata[2:0];
				`NPB_OFF_MASK: st_next.mask = hwdata[4:0];
				default: begin
				end
			endcase
		end
		st_next.ph_wr = aphase && hwrite && (haddr[31:8] == 24'h0);
		st_next.ph_addr = haddr[7:0];
		if (aphase && !hwrite) begin
			st_next.hrdata = 32'h0;
			if (haddr[31:8] != 24'h0) begin
				st_next.hrdata = 32'h0;
			end else if (haddr[7:0] < `NPB_OFF_PDATA_END) begin
				st_next.hrdata[3:0] = port_rd(pin[haddr[5:2]],
					st_reg.lat[haddr[5:2]], dirv[haddr[5:2]],
					is_od(int'(haddr[5:2])));
			end else begin
				case (haddr[7:0])
					`NPB_OFF_PAIR45: st_next.hrdata[7:0] = {
						port_rd(pin[5], st_reg.lat[5], dirv[5], 1'b1),
						port_rd(pin[4], st_reg.lat[4], dirv[4], 1'b1)};
					`NPB_OFF_PAIR67: st_next.hrdata[7:0] = {
						port_rd(pin[7], st_reg.lat[7], dirv[7], 1'b0),
						port_rd(pin[6], st_reg.lat[6], dirv[6], 1'b0)};
					`NPB_OFF_DIRG: st_next.hrdata[6:0] = st_reg.dir_grp;
					`NPB_OFF_DIRB: st_next.hrdata[7:0] = st_reg.dir_bit;
					`NPB_OFF_PULL: st_next.hrdata[7:0] = st_reg.pu;
					`NPB_OFF_ALT: st_next.hrdata[4:0] = st_reg.alt;
					`NPB_OFF_EDGE: st_next.hrdata[2:0] = st_reg.edge_sel;
					`NPB_OFF_STAT: begin
						st_next.hrdata[4:0] = st_reg.status;
						clr = st_reg.status;
					end
					`NPB_OFF_MASK: st_next.hrdata[4:0] = st_reg.mask;
					`NPB_OFF_TEST: st_next.hrdata[0] = sub_osc_in;
					default: st_next.hrdata = 32'h0;
				endcase
			end
		end
		// a new edge in the clearing cycle survives the read
		st_next.status = (st_reg.status & ~clr) | ev;
		st_next.irq = |(st_reg.status & st_reg.mask);
		st_next.cmp = pin[10][3];
		st_next.evc = pin[1][3];
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
			st_reg.poe_b <= '1;
			st_reg.hreadyout <= `NPB_RST_READY;
		end else if (ce) begin
			st_reg <= st_next;
		end
	end

	// ==========================================================
	// outputs
	// ==========================================================
	assign hrdata = st_reg.hrdata;
	assign hreadyout = st_reg.hreadyout;
	assign hresp = st_reg.hresp;
	assign p2_out = st_reg.pout[2];
	assign p2_oe_b = st_reg.poe_b[2];
	assign p3_out = st_reg.pout[3];
	assign p3_oe_b = st_reg.poe_b[3];
	assign p4_out = st_reg.pout[4];
	assign p4_oe_b = st_reg.poe_b[4];
	assign p5_out = st_reg.pout[5];
	assign p5_oe_b = st_reg.poe_b[5];
	assign p6_out = st_reg.pout[6];
	assign p6_oe_b = st_reg.poe_b[6];
	assign p7_out = st_reg.pout[7];
	assign p7_oe_b = st_reg.poe_b[7];
	assign p8_out = st_reg.pout[8];
	assign p8_oe_b = st_reg.poe_b[8];
	assign p9_out = st_reg.pout[9];
	assign p9_oe_b = st_reg.poe_b[9];
	assign p10_out = st_reg.pout[10];
	assign p10_oe_b = st_reg.poe_b[10];
	assign pu_p0 = {3{st_reg.pu[`NPB_PU_P0]}};
	assign pu_p1 = {4{st_reg.pu[`NPB_PU_P1]}};
	assign pu_p2 = {4{st_reg.pu[`NPB_PU_P2]}};
	assign pu_p3 = {4{st_reg.pu[`NPB_PU_P3]}};
	assign pu_p6 = {4{st_reg.pu[`NPB_PU_P6]}};
	assign pu_p7 = {4{st_reg.pu[`NPB_PU_P7]}};
	assign pu_p8 = {4{st_reg.pu[`NPB_PU_P8]}};
	assign pu_p9 = {4{st_reg.pu[`NPB_PU_P9]}};
	assign comparator_in = st_reg.cmp;
	assign event_count_input = st_reg.evc;
	assign irq = st_reg.irq;

	// ==========================================================
	// assertions
	// ==========================================================
	sequence s_wr_dirb;
		aphase && hwrite && (haddr == 32'(`NPB_OFF_DIRB)) ##1 hready;
	endsequence

	property p_pu0_group;
		@(posedge sys_clk) disable iff (!rst_n)
		(pu_p0 == 3'h0) || (pu_p0 == 3'h7);
	endproperty
	a_pu0_group: assert property (p_pu0_group)
		else $error("input_port_a pull-ups split");

	property p_pu_group;
		@(posedge sys_clk) disable iff (!rst_n)
		$changed(st_reg.pu[`NPB_PU_P8]) |-> pu_p8 == {4{pu_p8[0]}};
	endproperty
	a_pu_group: assert property (p_pu_group)
		else $error("port8 pull-ups split");

	property p_dir_bit;
		@(posedge sys_clk) disable iff (!rst_n || !ce)
		s_wr_dirb |-> ##2 (p3_oe_b == ~$past(hwdata[3:0], 2));
	endproperty
	a_dir_bit: assert property (p_dir_bit)
		else $error("port3 direction not per bit");

	property p_dir_group;
		@(posedge sys_clk) disable iff (!rst_n)
		(p8_oe_b == 4'h0) || (p8_oe_b == 4'hf);
	endproperty
	a_dir_group: assert property (p_dir_group)
		else $error("port8 direction split");

	property p_rst_in;
		@(posedge sys_clk)
		$rose(rst_n) |-> (&p3_oe_b) && (&p6_oe_b) && (&p4_oe_b)
			&& (&p10_oe_b) && (&p2_oe_b);
	endproperty
	a_rst_in: assert property (p_rst_in)
		else $error("pin driven after reset");

	property p_irq_d_edge;
		@(posedge sys_clk) disable iff (!rst_n || !ce)
		$changed(input_port_a[0]) && (input_port_a[0] == st_reg.edge_sel[0])
			|-> ##1 ev[`NPB_EV_IRQ_D];
	endproperty
	a_irq_d_edge: assert property (p_irq_d_edge)
		else $error("ext_irq_d edge missed");

	property p_test_edge;
		@(posedge sys_clk) disable iff (!rst_n || !ce)
		$rose(p1_in[2]) |-> ##1 ev[`NPB_EV_TEST];
	endproperty
	a_test_edge: assert property (p_test_edge)
		else $error("test edge missed");

	property p_key_fall;
		@(posedge sys_clk) disable iff (!rst_n || !ce)
		(|($past({p7_in, p6_in}) & ~{p7_in, p6_in}))
			|-> ##1 ev[`NPB_EV_KEY];
	endproperty
	a_key_fall: assert property (p_key_fall)
		else $error("key falling edge missed");

	property p_set_wins;
		@(posedge sys_clk) disable iff (!rst_n || !ce)
		(|ev) |=> ((st_reg.status & $past(ev)) == $past(ev));
	endproperty
	a_set_wins: assert property (p_set_wins)
		else $error("edge flag lost");

endmodule // npb_top

`default_nettype wire

// *** dv/npb_pin_model.sv ***
// board-side model of the port pins of ports 2 to 10.
// assumes the board drives every pin weakly; pad and pull-ups override it.
`timescale 1ns/1ps
`default_nettype none

module npb_pin_model (
	// pad side of the block, index 0 = port 2
	input wire logic [8:0][3:0] out_v,
	input wire logic [8:0][3:0] oe_v,
	input wire logic [8:0][3:0] pu_v,
	// weak board level, seen only where nothing else sets the pin
	input wire logic [8:0][3:0] bd_v,
	output logic [8:0][3:0] pin_v
);
	// ==========================================================
	// pin resolution
	// ==========================================================
	// a driven pad wins, then the pull-up, then the board
	always_comb begin
		for (int i = 0; i < 9; i++) begin
			for (int j = 0; j < 4; j++) begin
				if (oe_v[i][j] === 1'b0)
					pin_v[i][j] = out_v[i][j];
				else if (pu_v[i][j] === 1'b1)
					pin_v[i][j] = 1'b1;
				else
					pin_v[i][j] = bd_v[i][j];
			end
		end
	end
endmodule // npb_pin_model

`default_nettype wire

// *** dv/test_nibble_port_block.sv ***
// bus-driven bench of the nibble port block with a pin model.
// assumes zero-wait AHB-Lite answers and a 13-cycle input filter.
`timescale 1ns/1ps
`default_nettype none
`include "npb_cfg.svh"

module test_nibble_port_block;
	logic sys_clk, rst_b, ce, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rv;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [3:0] ipa, p1, an;
	logic sosc, tso, mpo, pco, bpo, ric, itc, azc, cmp, evc, irq;
	logic [2:0] pu_p0;
	logic [3:0] pu_p1, pu_p2, pu_p3, pu_p6, pu_p7, pu_p8, pu_p9;
	logic [8:0][3:0] pin_v, out_v, oe_v, pu_v, bd_v;
	int error_cnt = 0;
	int n_tests = 0;

	assign hready = hreadyout;
	// open-drain ports 4, 5 and 10 have no switchable pull-up
	assign pu_v = {4'h0, pu_p9, pu_p8, pu_p7, pu_p6, 8'h00, pu_p3, pu_p2};

	npb_top npb_top_i (.sys_clk(sys_clk), .rst_b(rst_b), .ce(ce),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .input_port_a(ipa),
		.p1_in(p1), .analog_shared_input_port(an), .sub_osc_in(sosc),
		.p2_in(pin_v[0]), .p2_out(out_v[0]), .p2_oe_b(oe_v[0]),
		.p3_in(pin_v[1]), .p3_out(out_v[1]), .p3_oe_b(oe_v[1]),
		.p4_in(pin_v[2]), .p4_out(out_v[2]), .p4_oe_b(oe_v[2]),
		.p5_in(pin_v[3]), .p5_out(out_v[3]), .p5_oe_b(oe_v[3]),
		.p6_in(pin_v[4]), .p6_out(out_v[4]), .p6_oe_b(oe_v[4]),
		.p7_in(pin_v[5]), .p7_out(out_v[5]), .p7_oe_b(oe_v[5]),
		.p8_in(pin_v[6]), .p8_out(out_v[6]), .p8_oe_b(oe_v[6]),
		.p9_in(pin_v[7]), .p9_out(out_v[7]), .p9_oe_b(oe_v[7]),
		.p10_in(pin_v[8]), .p10_out(out_v[8]), .p10_oe_b(oe_v[8]),
		.pu_p0(pu_p0), .pu_p1(pu_p1), .pu_p2(pu_p2), .pu_p3(pu_p3),
		.pu_p6(pu_p6), .pu_p7(pu_p7), .pu_p8(pu_p8), .pu_p9(pu_p9),
		.timer_square_out(tso), .mft_pulse_out(mpo),
		.prog_clock_out(pco), .beeper_out(bpo),
		.reverse_integrate_ctl(ric), .integrate_ctl(itc),
		.autozero_ctl(azc), .comparator_in(cmp),
		.event_count_input(evc), .irq(irq));

	npb_pin_model npb_pin_model_i (.out_v(out_v), .oe_v(oe_v),
		.pu_v(pu_v), .bd_v(bd_v), .pin_v(pin_v));

	// ==========================================================
	// tasks
	// ==========================================================
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// one single transfer; waits are bounded by the watchdog only
	task automatic bus(input logic wr, input logic [7:0] a,
			input logic [31:0] wd, output logic [31:0] rd);
		@(posedge sys_clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		do @(posedge sys_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge sys_clk); while (hready !== 1'b1);
		rd = hrdata;
		chk(hresp, 1'b0);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		bus(1'b1, a, d, dummy);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		bus(1'b0, a, 32'h0, d);
		chk(d, exp);
	endtask

	// ==========================================================
	// clock, watchdog, tests
	// ==========================================================
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	// whole run is well under 2000 cycles
	initial begin
		#(8 * 20000);
		error_cnt++;
		test_done();
	end

	initial begin
		rst_b = 1'b0;
		ce = 1'b1;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'h2;
		{ipa, p1, tso, mpo, pco, bpo, ric, itc, azc} = '0;
		an = 4'h6;
		sosc = 1'b1;
		bd_v = {12'h999, 8'hff, 16'h9999};
		idle(5);
		rst_b <= 1'b1;
		idle(5);
		chk(&oe_v, 1'b1);
		chk(|{pu_p0, pu_p1, pu_p2, pu_p3, pu_v}, 1'b0);
		chk(irq, 1'b0);
		wr(`NPB_OFF_PULL, 32'hff);
		idle(2);
		chk({pu_p0, pu_p1, pu_p2, pu_p3}, 15'h7fff);
		chk({pu_p6, pu_p7, pu_p8, pu_p9}, 16'hffff);
		wr(`NPB_OFF_PULL, 32'h01);
		idle(2);
		chk(pu_p0, 3'h7);
		chk({pu_p1, pu_p2, pu_p3, pu_p6, pu_p7, pu_p8, pu_p9}, 0);
		wr(`NPB_OFF_DIRB, 32'h05);
		idle(3);
		chk(oe_v[1], 4'ha);
		chk(oe_v[4], 4'hf);
		wr(`NPB_OFF_DIRG, 32'h1 << `NPB_DG_P8);
		wr(8'h20, 32'h6);
		idle(3);
		chk({oe_v[6], out_v[6], oe_v[0]}, 12'h06f);
		rdc(8'h20, 32'h6);
		// open-drain pair: low latch bits pull, high bits release
		wr(`NPB_OFF_DIRG, 32'h06);
		wr(`NPB_OFF_PAIR45, 32'h0f);
		idle(3);
		chk({oe_v[3], oe_v[2]}, 8'h0f);
		rdc(`NPB_OFF_PAIR45, 32'h09);
		wr(`NPB_OFF_DIRB, 32'hf0);
		wr(`NPB_OFF_DIRG, 32'h1 << `NPB_DG_P7);
		wr(`NPB_OFF_PAIR67, 32'h3c);
		idle(3);
		chk({out_v[5], out_v[4]}, 8'h3c);
		rdc(`NPB_OFF_PAIR67, 32'h3c);
		wr(`NPB_OFF_DIRB, 32'h0);
		wr(`NPB_OFF_DIRG, 32'h0);
		ipa <= 4'he;
		p1 <= 4'h8;
		idle(3);
		rdc(8'h00, 32'he);
		rdc(8'h04, 32'h8);
		chk(evc, 1'b1);
		rdc(8'h2c, 32'h6);
		rdc(`NPB_OFF_TEST, 32'h1);
		rdc(8'h60, 32'h0);
		{tso, mpo, pco, bpo, ric, itc, azc} <= 7'b1010010;
		wr(`NPB_OFF_ALT, 32'h1f);
		idle(3);
		chk({out_v[0], oe_v[0]}, 8'h50);
		chk({oe_v[8], cmp}, 5'h15);
		wr(`NPB_OFF_ALT, 32'h0);
		wr(`NPB_OFF_MASK, 32'h1f);
		wr(`NPB_OFF_EDGE, 32'h07);
		idle(20);
		// pin changes above may have left flags; this read clears them
		bus(1'b0, `NPB_OFF_STAT, 32'h0, rv);
		// a 4-cycle pulse passes the unfiltered input only
		p1[1:0] <= 2'h3;
		idle(4);
		p1[1:0] <= 2'h0;
		idle(20);
		rdc(`NPB_OFF_STAT, 32'h04);
		ipa[0] <= 1'b1;
		p1[2:0] <= 3'h7;
		bd_v[4][2] <= 1'b0;
		idle(20);
		chk(irq, 1'b1);
		rdc(`NPB_OFF_STAT, 32'h1f);
		idle(3);
		chk(irq, 1'b0);
		rdc(`NPB_OFF_STAT, 32'h0);
		bd_v[4][2] <= 1'b1;
		wr(`NPB_OFF_MASK, 32'h0);
		wr(`NPB_OFF_EDGE, 32'h0);
		ipa[0] <= 1'b0;
		p1[2:0] <= 3'h0;
		idle(20);
		chk(irq, 1'b0);
		rdc(`NPB_OFF_STAT, 32'h07);
		bd_v[5][0] <= 1'b0;
		idle(6);
		rdc(`NPB_OFF_STAT, 32'h10);
		// port3 and port9 drive their latches, then a mid-run reset
		wr(`NPB_OFF_DIRB, 32'h0f);
		wr(`NPB_OFF_DIRG, 32'h7f);
		wr(8'h0c, 32'ha);
		wr(8'h24, 32'h5);
		idle(3);
		chk({out_v[1], oe_v[1]}, 8'ha0);
		chk({out_v[7], oe_v[7]}, 8'h50);
		rst_b <= 1'b0;
		idle(2);
		rst_b <= 1'b1;
		idle(4);
		chk(&oe_v, 1'b1);
		chk(|out_v, 1'b0);
		rdc(`NPB_OFF_DIRG, 32'h0);
		// a frozen block must not see a test edge
		ce <= 1'b0;
		idle(2);
		p1[2] <= 1'b1;
		idle(3);
		p1[2] <= 1'b0;
		idle(2);
		ce <= 1'b1;
		idle(3);
		rdc(`NPB_OFF_STAT, 32'h0);
		test_done();
	end
endmodule // test_nibble_port_block

`default_nettype wire
